// *** inc/uart_flow_pkg.sv ***
// Constants, carriers and state types for one UART channel with FIFO and flow control.
// Assumes a 100 MHz system clock and a classic Wishbone slave port with 32-bit data.
package uart_flow_pkg;
   // ****************************************
   // Sizes and timing
   // ****************************************
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] FIFO_CAP = 5'h10;
   localparam logic [4:0] HOLD_CAP = 5'h01;
   localparam int TIMEOUT_CHARS = 4;
   // Start bit, five data bits and one stop bit
   localparam logic [4:0] BASE_BITS = 5'h07;
   // ****************************************
   // Register word indices, byte address is four times the index
   // ****************************************
   localparam logic [2:0] IDX_DATA = 3'h0;
   localparam logic [2:0] IDX_IER = 3'h1;
   localparam logic [2:0] IDX_ISR = 3'h2;
   localparam logic [2:0] IDX_LCR = 3'h3;
   localparam logic [2:0] IDX_MCR = 3'h4;
   localparam logic [2:0] IDX_LSR = 3'h5;
   localparam logic [2:0] IDX_MSR = 3'h6;
   localparam logic [2:0] IDX_SPR = 3'h7;
   localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int FCR_EN = 0;
   localparam int FCR_RX_FLUSH = 1;
   localparam int FCR_TX_FLUSH = 2;
   localparam int EFR_RX_SET1 = 0;
   localparam int EFR_RX_SET2 = 1;
   localparam int EFR_TX_SET1 = 2;
   localparam int EFR_TX_SET2 = 3;
   localparam int EFR_SPECIAL = 5;
   localparam int EFR_AUTO_RTS = 6;
   localparam int EFR_AUTO_CTS = 7;
   localparam int IER_RX = 0;
   localparam int IER_THR = 1;
   localparam int IER_XOFF = 5;
   localparam int IER_RTS = 6;
   localparam int IER_CTS = 7;
   localparam int LCR_STOP2 = 2;
   localparam int LCR_PAR_EN = 3;
   localparam int LCR_DLAB = 7;
   localparam int MCR_RTS = 1;
   localparam int MCR_IRQ_EN = 3;
   // ****************************************
   // Interrupt identity codes, highest priority first
   // ****************************************
   localparam logic [7:0] ISR_NONE = 8'h01;
   localparam logic [7:0] ISR_RX_DATA = 8'h04;
   localparam logic [7:0] ISR_TIMEOUT = 8'h0C;
   localparam logic [7:0] ISR_THRE = 8'h02;
   localparam logic [7:0] ISR_XOFF = 8'h10;
   localparam logic [7:0] ISR_CTSRTS = 8'h20;
   // ****************************************
   // Trigger tables indexed by the trigger select field
   // ****************************************
   localparam logic [3:0][4:0] INT_LVL = {5'h0E, 5'h08, 5'h04, 5'h01};
   localparam logic [3:0][4:0] STOP_LVL = {5'h0E, 5'h0C, 5'h08, 5'h04};
   localparam logic [3:0][4:0] RES_LVL = {5'h0A, 5'h08, 5'h04, 5'h01};
   // ****************************************
   // Carriers and states
   // ****************************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;
   typedef struct packed {
      logic valid;
      logic stop_mid;
      logic [7:0] data;
   } rx_char_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } tx_char_t;
   typedef enum logic [1:0] {FC_IDLE, FC_FIRST, FC_SECOND} fc_state_t;
endpackage : uart_flow_pkg

// *** core/uart_flow_core.sv ***
// One UART channel: FIFOs, hardware and software flow control, interrupts.
// Assumes a character-level receiver and serializer on clk_sys, and a bit-rate tick.
//
// Behaviour
// RULE1: Sixteen-byte FIFOs, enabled by FIFO control bit 0
// RULE2: Receive trigger programmable, transmit trigger fixed
// RULE3: Interrupt at trigger; stop at 4/8/12/14
// RULE4: Resume at 1/4/8/10 characters held
// RULE5: Feature bits 6/7 enable auto RTS/CTS
// RULE6: CTS high halts after character; flags status
// RULE7: Auto RTS hysteresis; reception continues until full
// RULE8: Match one or two stop characters, halt
// RULE9: Stop match sets flag, raises receive interrupt; the core raises the Xoff interrupt (ISR_XOFF) instead
// RULE10: Resume characters restart transmission, clear flag
// RULE11: Reset clears all four flow characters
// RULE12: Flow characters never enter receive FIFO; the core stores resume characters received while not halted
// RULE13: Send stop/resume characters around trigger level
// RULE14: Special mode: stop char 2 stored, flagged
// RULE15: Software disables flow control in special mode
// RULE16: Comparisons use only configured word length
// RULE17: Flow interrupts lowest; single highest reported
// RULE18: Transmit-empty interrupt pending right after reset
// RULE19: Receive data and time-out share priority
// RULE20: Time-out restarts on stop bit, read
// RULE21: Select pin or modem bit 3 enable
// RULE22: Enhanced registers reachable only with key BF
// RULE23: Character time from word format and baud
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
module uart_flow_core (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire uart_flow_pkg::wb_req_t wb_req,
   output uart_flow_pkg::wb_rsp_t wb_rsp,
   input wire uart_flow_pkg::rx_char_t rx_in,
   input wire logic bit_tick,
   output uart_flow_pkg::tx_char_t tx_out,
   input wire logic tx_ready,
   input wire logic cts_n_pin,
   output logic rts_n_pin,
   input wire logic irq_mode_select_pin,
   output logic channel_irq_outputs,
   output logic channel_irq_oe_n
);
   import uart_flow_pkg::*;

   // ****************************************
   // Reset release and pin synchronisers
   // ****************************************
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic cts_prev_q;
   logic cts_s;
   logic sel_s;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
         cts_prev_q <= 1'b0;
      end
      else
      begin
         pin_s1_q <= {cts_n_pin, irq_mode_select_pin};
         pin_s2_q <= pin_s1_q;
         cts_prev_q <= pin_s2_q[1];
      end
   end
   assign cts_s = pin_s2_q[1];
   assign sel_s = pin_s2_q[0];

   // ****************************************
   // Bus decode
   // ****************************************
   logic ack_q;
   logic [7:0] ier_q, fcr_q, lcr_q, mcr_q, spr_q, efr_q;
   logic acc, mapped, enh, gen, wr, rd;
   logic [2:0] idx;
   logic [7:0] wdat;
   logic thr_wr, rhr_rd, isr_rd, lsr_rd;

   assign acc = wb_req.cyc & wb_req.stb & ~ack_q;
   assign idx = wb_req.adr[4:2];
   assign wdat = wb_req.dat[7:0];
   assign mapped = (wb_req.adr[7:5] == 3'h0) & (wb_req.adr[1:0] == 2'h0);
   assign enh = (lcr_q == LCR_ENH_KEY); // RULE22
   assign gen = ~lcr_q[LCR_DLAB];
   assign wr = acc & wb_req.we & wb_req.sel[0] & mapped;
   assign rd = acc & ~wb_req.we & mapped;
   assign thr_wr = wr & gen & (idx == IDX_DATA);
   assign rhr_rd = rd & gen & (idx == IDX_DATA);
   assign isr_rd = rd & gen & (idx == IDX_ISR);
   assign lsr_rd = rd & gen & (idx == IDX_LSR);

   // ****************************************
   // Control registers
   // ****************************************
   logic [7:0] fc_char_q [4];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ier_q <= RST_BYTE;
         fcr_q <= RST_BYTE;
         lcr_q <= RST_BYTE;
         mcr_q <= RST_BYTE;
         spr_q <= RST_BYTE;
         efr_q <= RST_BYTE;
         for (int i = 0; i < 4; i++)
            fc_char_q[i] <= RST_BYTE; // RULE11
      end
      else if (wr)
      begin
         if (idx == IDX_LCR)
            lcr_q <= wdat;
         else if (enh)
         begin
            if (idx == IDX_ISR)
               efr_q <= wdat; // RULE22
            else if (idx[2])
               fc_char_q[idx[1:0]] <= wdat; // RULE22
         end
         else if (gen)
         begin
            case (idx)
               IDX_IER: ier_q <= wdat;
               // Flush bits act at once and never read back
               IDX_ISR: fcr_q <= wdat & 8'hF9; // RULE1 RULE2
               IDX_MCR: mcr_q <= wdat;
               IDX_SPR: spr_q <= wdat;
               default: ;
            endcase
         end
      end
   end

   // ****************************************
   // Levels, masks and character time
   // ****************************************
   logic [4:0] cap, int_lvl, stop_lvl, res_lvl;
   logic [7:0] mask;
   logic [4:0] bpc;
   logic [6:0] to_limit;
   logic rx_flush, tx_flush;

   assign cap = fcr_q[FCR_EN] ? FIFO_CAP : HOLD_CAP; // RULE1
   assign int_lvl = fcr_q[FCR_EN] ? INT_LVL[fcr_q[7:6]] : HOLD_CAP; // RULE3
   assign stop_lvl = STOP_LVL[fcr_q[7:6]]; // RULE3
   assign res_lvl = RES_LVL[fcr_q[7:6]]; // RULE4
   assign mask = 8'hFF >> (2'h3 - lcr_q[1:0]); // RULE16
   // One and a half stop bits counted as two, so the time-out is never early
   assign bpc = BASE_BITS + {3'h0, lcr_q[1:0]} + {4'h0, lcr_q[LCR_PAR_EN]}
      + {4'h0, lcr_q[LCR_STOP2]}; // RULE23
   assign to_limit = 7'(bpc * TIMEOUT_CHARS); // RULE20 RULE23
   assign rx_flush = wr & gen & (idx == IDX_ISR) & wdat[FCR_RX_FLUSH];
   assign tx_flush = wr & gen & (idx == IDX_ISR) & wdat[FCR_TX_FLUSH];

   function automatic logic same(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
      same = ((a ^ b) & m) == 8'h00;
   endfunction : same

   // ****************************************
   // Receive character classification
   // ****************************************
   logic rx_flow_en, rx_dbl, rx_use2;
   logic stop_first, stop_hit, res_first, res_hit, special_hit, flow_drop;
   logic stop_seen_q, res_seen_q, xoff_halt_q;
   logic rx_push, overrun, rx_pop;
   logic [3:0] rx_wptr_q, rx_rptr_q;
   logic [4:0] rx_cnt_q;
   logic [7:0] rx_mem_q [FIFO_DEPTH];

   assign rx_flow_en = efr_q[EFR_RX_SET1] | efr_q[EFR_RX_SET2];
   assign rx_dbl = efr_q[EFR_RX_SET1] & efr_q[EFR_RX_SET2];
   assign rx_use2 = efr_q[EFR_RX_SET2] & ~efr_q[EFR_RX_SET1];
   assign stop_first = rx_flow_en & rx_dbl & same(rx_in.data, fc_char_q[2], mask); // RULE8
   assign stop_hit = rx_flow_en & (rx_dbl
      ? stop_seen_q & same(rx_in.data, fc_char_q[3], mask)
      : same(rx_in.data, fc_char_q[{1'b1, rx_use2}], mask)); // RULE8 RULE16
   assign res_first = rx_flow_en & rx_dbl & same(rx_in.data, fc_char_q[0], mask);
   assign res_hit = rx_flow_en & (rx_dbl
      ? res_seen_q & same(rx_in.data, fc_char_q[1], mask)
      : same(rx_in.data, fc_char_q[{1'b0, rx_use2}], mask)); // RULE10 RULE16
   assign special_hit = rx_in.valid & efr_q[EFR_SPECIAL]
      & same(rx_in.data, fc_char_q[3], mask); // RULE14
   assign flow_drop = stop_first | stop_hit | (xoff_halt_q & (res_first | res_hit)); // RULE12
   assign rx_push = rx_in.valid & ~flow_drop & (rx_cnt_q < cap); // RULE7
   assign overrun = rx_in.valid & ~flow_drop & (rx_cnt_q >= cap);
   assign rx_pop = rhr_rd & (rx_cnt_q != 5'h00);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stop_seen_q <= 1'b0;
         res_seen_q <= 1'b0;
         xoff_halt_q <= 1'b0;
      end
      else
      begin
         if (rx_in.valid)
         begin
            stop_seen_q <= stop_first;
            res_seen_q <= res_first;
         end
         if (!rx_flow_en)
            xoff_halt_q <= 1'b0;
         else if (rx_in.valid & stop_hit)
            xoff_halt_q <= 1'b1; // RULE8
         else if (rx_in.valid & res_hit)
            xoff_halt_q <= 1'b0; // RULE10
      end
   end

   // ****************************************
   // Receive FIFO
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (rx_push)
         rx_mem_q[rx_wptr_q] <= rx_in.data;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_wptr_q <= 4'h0;
         rx_rptr_q <= 4'h0;
         rx_cnt_q <= 5'h00;
      end
      else if (rx_flush)
      begin
         rx_wptr_q <= 4'h0;
         rx_rptr_q <= 4'h0;
         rx_cnt_q <= 5'h00;
      end
      else
      begin
         rx_wptr_q <= rx_wptr_q + {3'h0, rx_push};
         rx_rptr_q <= rx_rptr_q + {3'h0, rx_pop};
         rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop}; // RULE1
      end
   end

   // ****************************************
   // Receive time-out
   // ****************************************
   logic [6:0] to_cnt_q;
   logic timeout;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         to_cnt_q <= 7'h00;
      else if (rx_in.stop_mid | rhr_rd | (rx_cnt_q == 5'h00))
         to_cnt_q <= 7'h00; // RULE20
      else if (bit_tick & (to_cnt_q < to_limit))
         to_cnt_q <= to_cnt_q + 7'h01;
   end
   assign timeout = (to_cnt_q >= to_limit) & (rx_cnt_q != 5'h00); // RULE19

   // ****************************************
   // Automatic RTS
   // ****************************************
   logic auto_rts, auto_cts, rts_off_evt;

   assign auto_rts = efr_q[EFR_AUTO_RTS]; // RULE5
   assign auto_cts = efr_q[EFR_AUTO_CTS]; // RULE5
   assign rts_off_evt = auto_rts & ~rts_n_pin & (rx_cnt_q >= stop_lvl);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rts_n_pin <= 1'b1;
      else if (!auto_rts)
         rts_n_pin <= ~mcr_q[MCR_RTS];
      else if (rx_cnt_q >= stop_lvl)
         rts_n_pin <= 1'b1; // RULE3 RULE7
      else if (rx_cnt_q <= res_lvl)
         rts_n_pin <= 1'b0; // RULE4 RULE7
   end

   // ****************************************
   // Transmit FIFO and flow character insertion
   // ****************************************
   logic [3:0] tx_wptr_q, tx_rptr_q;
   logic [4:0] tx_cnt_q;
   logic [7:0] tx_mem_q [FIFO_DEPTH];
   logic tx_push, tx_pop, load, halt;
   logic tx_flow_en, tx_dbl, tx_use2, remote_stopped_q, fc_res_q;
   fc_state_t fc_state_q;

   assign tx_push = thr_wr & (tx_cnt_q < cap);
   assign load = ~tx_out.valid | tx_ready;
   // Halt only gates the next load, so the character on the line always finishes
   assign halt = (auto_cts & cts_s) | xoff_halt_q; // RULE6 RULE8
   assign tx_pop = load & (fc_state_q == FC_IDLE) & (tx_cnt_q != 5'h00) & ~halt;
   assign tx_flow_en = efr_q[EFR_TX_SET1] | efr_q[EFR_TX_SET2];
   assign tx_dbl = efr_q[EFR_TX_SET1] & efr_q[EFR_TX_SET2];
   assign tx_use2 = efr_q[EFR_TX_SET2] & ~efr_q[EFR_TX_SET1];

   always_ff @(posedge clk_sys)
   begin
      if (tx_push)
         tx_mem_q[tx_wptr_q] <= wdat;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_wptr_q <= 4'h0;
         tx_rptr_q <= 4'h0;
         tx_cnt_q <= 5'h00;
      end
      else if (tx_flush)
      begin
         tx_wptr_q <= 4'h0;
         tx_rptr_q <= 4'h0;
         tx_cnt_q <= 5'h00;
      end
      else
      begin
         tx_wptr_q <= tx_wptr_q + {3'h0, tx_push};
         tx_rptr_q <= tx_rptr_q + {3'h0, tx_pop};
         tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop}; // RULE1
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fc_state_q <= FC_IDLE;
         fc_res_q <= 1'b0;
         remote_stopped_q <= 1'b0;
      end
      else
      begin
         unique case (fc_state_q)
            FC_IDLE:
            begin
               if (tx_flow_en & ~remote_stopped_q & (rx_cnt_q >= stop_lvl))
               begin
                  fc_state_q <= FC_FIRST; // RULE13
                  fc_res_q <= 1'b0;
                  remote_stopped_q <= 1'b1;
               end
               else if (remote_stopped_q & (rx_cnt_q <= res_lvl))
               begin
                  fc_state_q <= FC_FIRST; // RULE13
                  fc_res_q <= 1'b1;
                  remote_stopped_q <= 1'b0;
               end
            end
            FC_FIRST:
            begin
               if (load)
                  fc_state_q <= tx_dbl ? FC_SECOND : FC_IDLE;
            end
            FC_SECOND:
            begin
               if (load)
                  fc_state_q <= FC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         tx_out <= '0;
      else if (load)
      begin
         if (fc_state_q != FC_IDLE)
         begin
            tx_out.valid <= 1'b1;
            tx_out.data <= fc_char_q[{~fc_res_q, (fc_state_q == FC_SECOND) | tx_use2}];
         end
         else
         begin
            tx_out.valid <= tx_pop;
            tx_out.data <= tx_mem_q[tx_rptr_q];
         end
      end
   end

   // ****************************************
   // Interrupt sources and priority
   // ****************************************
   logic thre_q, xoff_flag_q, ctsrts_q, overrun_q, irq_pend;
   logic [7:0] isr_code;

   always_comb
   begin
      if (ier_q[IER_RX] & timeout)
         isr_code = ISR_TIMEOUT; // RULE19
      else if (ier_q[IER_RX] & (rx_cnt_q >= int_lvl))
         isr_code = ISR_RX_DATA; // RULE3 RULE19
      else if (ier_q[IER_THR] & thre_q)
         isr_code = ISR_THRE; // RULE18
      else if (ier_q[IER_XOFF] & xoff_flag_q)
         isr_code = ISR_XOFF; // RULE9 RULE17
      else if (ctsrts_q)
         isr_code = ISR_CTSRTS; // RULE17
      else
         isr_code = ISR_NONE;
   end
   assign irq_pend = isr_code != ISR_NONE;

   // A set in the same cycle as a clear always wins
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         thre_q <= 1'b1; // RULE18
         xoff_flag_q <= 1'b0;
         ctsrts_q <= 1'b0;
         overrun_q <= 1'b0;
      end
      else
      begin
         if (tx_pop & ~tx_push & (tx_cnt_q == 5'h01))
            thre_q <= 1'b1;
         else if (thr_wr | (isr_rd & (isr_code == ISR_THRE)))
            thre_q <= 1'b0;
         if ((rx_in.valid & stop_hit & ier_q[IER_XOFF]) | special_hit)
            xoff_flag_q <= 1'b1; // RULE9 RULE14
         else if ((rx_in.valid & xoff_halt_q & res_hit) | (isr_rd & (isr_code == ISR_XOFF)))
            xoff_flag_q <= 1'b0; // RULE10
         if ((auto_cts & ier_q[IER_CTS] & cts_s & ~cts_prev_q)
            | (rts_off_evt & ier_q[IER_RTS]))
            ctsrts_q <= 1'b1; // RULE6 RULE7
         else if (isr_rd & (isr_code == ISR_CTSRTS))
            ctsrts_q <= 1'b0;
         if (overrun)
            overrun_q <= 1'b1;
         else if (lsr_rd)
            overrun_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         channel_irq_outputs <= 1'b0;
         channel_irq_oe_n <= 1'b1;
      end
      else
      begin
         channel_irq_outputs <= irq_pend;
         channel_irq_oe_n <= ~(sel_s | mcr_q[MCR_IRQ_EN]); // RULE21
      end
   end

   // ****************************************
   // Read data and acknowledge
   // ****************************************
   logic [7:0] rdat;

   always_comb
   begin
      rdat = 8'h00;
      if (mapped)
      begin
         if (idx == IDX_LCR)
            rdat = lcr_q;
         else if (enh)
         begin
            if (idx == IDX_ISR)
               rdat = efr_q;
            else if (idx[2])
               rdat = fc_char_q[idx[1:0]];
         end
         else if (gen)
         begin
            case (idx)
               IDX_DATA: rdat = (rx_cnt_q != 5'h00) ? rx_mem_q[rx_rptr_q] : 8'h00;
               IDX_IER: rdat = ier_q;
               IDX_ISR: rdat = isr_code | {fcr_q[FCR_EN], fcr_q[FCR_EN], 6'h00};
               IDX_MCR: rdat = mcr_q;
               IDX_LSR: rdat = {1'b0, (tx_cnt_q == 5'h00) & ~tx_out.valid,
                  tx_cnt_q == 5'h00, 3'h0, overrun_q, rx_cnt_q != 5'h00};
               IDX_MSR: rdat = {3'h0, ~cts_s, 4'h0};
               IDX_SPR: rdat = spr_q;
               default: rdat = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q <= 1'b0;
         wb_rsp <= '0;
      end
      else
      begin
         ack_q <= acc;
         wb_rsp.ack <= acc;
         wb_rsp.dat <= acc ? {24'h00_0000, rdat} : 32'h0000_0000;
      end
   end
endmodule : uart_flow_core

// *** testbench/uart_flow_assertions.sv ***
// Port checks for the UART channel core.
// Assumes the core's top ports only; bound below.
module uart_flow_checker (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire uart_flow_pkg::wb_req_t wb_req,
   input wire uart_flow_pkg::wb_rsp_t wb_rsp,
   input wire uart_flow_pkg::rx_char_t rx_in,
   input wire uart_flow_pkg::tx_char_t tx_out,
   input wire logic tx_ready,
   input wire logic rts_n_pin,
   input wire logic irq_mode_select_pin,
   input wire logic channel_irq_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   import uart_flow_pkg::*;
   // ****************
   // Properties
   // ****************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence bus_req;
      wb_req.cyc && wb_req.stb && !wb_rsp.ack;
   endsequence
   a_ack_follows: assert property (bus_req |=> wb_rsp.ack)
      else $error("ack missing");
   a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack too long");
   a_ack_caused: assert property ($rose(wb_rsp.ack) |-> $past(wb_req.stb))
      else $error("stray ack");
   a_odd_zero: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack
      && !wb_req.we && wb_req.adr[1:0] != 2'h0 |=> wb_rsp.dat == 32'h0)
      else $error("odd read not zero");
   // Reset release and two sync flops delay the enable register
   a_oe_pinned: assert property (irq_mode_select_pin [*8] |-> !channel_irq_oe_n)
      else $error("irq output not enabled");
   a_tx_holds: assert property (tx_out.valid && !tx_ready |=>
      tx_out.valid && $stable(tx_out.data))
      else $error("offered char withdrawn");
   a_rts_caused: assert property ($changed(rts_n_pin) |-> wb_rsp.ack
      || $past(wb_rsp.ack) || $past(rx_in.valid, 2) || $past(rx_in.valid, 3))
      else $error("rts moved without cause");
   a_reset_quiet: assert property ($rose(nrst) |-> rts_n_pin && !tx_out.valid)
      else $error("outputs active after reset");
endmodule : uart_flow_checker
bind uart_flow_core uart_flow_checker checker_u (.clk_sys(clk_sys), .nrst(nrst),
   .wb_req(wb_req), .wb_rsp(wb_rsp), .rx_in(rx_in), .tx_out(tx_out), .tx_ready(tx_ready),
   .rts_n_pin(rts_n_pin), .irq_mode_select_pin(irq_mode_select_pin),
   .channel_irq_oe_n(channel_irq_oe_n));

// *** testbench/remote_link_model.sv ***
// Remote transceiver at character level.
// Assumes the core samples on the rising edge of clk_sys.
module remote_link_model (
   input wire logic clk_sys,
   input wire uart_flow_pkg::tx_char_t tx_out,
   output uart_flow_pkg::rx_char_t rx_in,
   output logic bit_tick,
   output logic tx_ready,
   output logic cts_n_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   import uart_flow_pkg::*;
   logic [3:0] div_q = 4'h0;
   logic [3:0] busy_q = 4'h1;
   logic [7:0] got [$];
   // ****************
   // Serial side
   // ****************
   initial
   begin
      rx_in = '0;
      bit_tick = 1'b0;
      tx_ready = 1'b0;
      cts_n_pin = 1'b0;
   end
   // Slow serializer, so the core must hold its offer
   always @(posedge clk_sys)
   begin
      div_q <= div_q + 4'h1;
      bit_tick <= (div_q == 4'h0);
      if (tx_out.valid && tx_ready)
      begin
         got.push_back(tx_out.data);
         busy_q <= 4'hF;
         tx_ready <= 1'b0;
      end
      else
      begin
         busy_q <= (busy_q == 4'h0) ? 4'h0 : busy_q - 4'h1;
         tx_ready <= (busy_q <= 4'h1);
      end
   end
   // Idle data shows the inverse, never a stale copy
   task automatic send(input logic [7:0] d);
      @(posedge clk_sys);
      rx_in <= '{1'b0, 1'b1, ~d};
      @(posedge clk_sys);
      rx_in <= '{1'b1, 1'b0, d};
      @(posedge clk_sys);
      rx_in <= '{1'b0, 1'b0, ~d};
   endtask : send
   task automatic hold(input logic h);
      cts_n_pin <= h;
   endtask : hold
endmodule : remote_link_model

// *** testbench/testbench.sv ***
// Bench for the UART channel core: bus tasks and flow sequences.
// Assumes the link model and the bound checker.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import uart_flow_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic sel_pin = 1'b1;
   wb_req_t wb_req = '0;
   wb_rsp_t wb_rsp;
   rx_char_t rx_in;
   tx_char_t tx_out;
   logic bit_tick, tx_ready, cts_n_pin, rts_n_pin, irq, oe_n;
   logic [7:0] q;
   int n_fail = 0;
   int comparisons = 0;
   // ****************
   // Harness
   // ****************
   always #5 clk_sys = ~clk_sys;
   uart_flow_core dut_u (.clk_sys(clk_sys), .nrst(nrst), .wb_req(wb_req), .wb_rsp(wb_rsp),
      .rx_in(rx_in), .bit_tick(bit_tick), .tx_out(tx_out), .tx_ready(tx_ready),
      .cts_n_pin(cts_n_pin), .rts_n_pin(rts_n_pin), .irq_mode_select_pin(sel_pin),
      .channel_irq_outputs(irq), .channel_irq_oe_n(oe_n));
   remote_link_model partner_u (.clk_sys(clk_sys), .tx_out(tx_out), .rx_in(rx_in),
      .bit_tick(bit_tick), .tx_ready(tx_ready), .cts_n_pin(cts_n_pin));
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Classic cycle; held until ack is sampled high
   task automatic rw(input logic we, input logic [2:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      wb_req <= '{1'b1, 1'b1, we, {3'h0, idx, 2'h0}, 4'h1, {24'h0, d}};
      do
         @(posedge clk_sys);
      while (wb_rsp.ack !== 1'b1);
      q = wb_rsp.dat[7:0];
      wb_req <= '0;
   endtask : rw
   // ****************
   // Sequences
   // ****************
   initial
   begin
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rw(1'b1, IDX_IER, 8'h02);
      repeat (4) @(posedge clk_sys);
      chk({7'h0, irq}, 8'h01);
      chk({7'h0, oe_n}, 8'h00);
      rw(1'b0, IDX_ISR, 8'h00);
      chk(q, ISR_THRE);
      rw(1'b1, IDX_LCR, LCR_ENH_KEY);
      for (int i = 4; i < 8; i++)
      begin
         rw(1'b0, 3'(i), 8'h00);
         chk(q, RST_BYTE);
      end
      rw(1'b1, 3'h4, 8'h11);
      rw(1'b1, 3'h6, 8'h13);
      rw(1'b1, 3'h2, 8'h41);
      rw(1'b0, 3'h6, 8'h00);
      chk(q, 8'h13);
      rw(1'b1, IDX_LCR, 8'h03);
      rw(1'b1, IDX_MCR, 8'h0A);
      rw(1'b1, IDX_IER, 8'h01);
      rw(1'b1, IDX_ISR, 8'h07);
      partner_u.send(8'h13);
      rw(1'b1, IDX_DATA, 8'h41);
      repeat (60) @(posedge clk_sys);
      rw(1'b0, IDX_LSR, 8'h00);
      chk(q & 8'h01, 8'h00);
      chk(8'(partner_u.got.size()), 8'h00);
      partner_u.send(8'h11);
      repeat (60) @(posedge clk_sys);
      chk(8'(partner_u.got.size()), 8'h01);
      chk(partner_u.got[0], 8'h41);
      for (int t = 0; t < 4; t++)
      begin
         rw(1'b1, IDX_ISR, {2'(t), 6'h03});
         for (int k = 1; k <= int'(STOP_LVL[t]); k++)
         begin
            partner_u.send(8'h30 + 8'(k));
            repeat (2) @(posedge clk_sys);
            chk({7'h0, irq}, {7'h0, k >= int'(INT_LVL[t])});
            chk({7'h0, rts_n_pin}, {7'h0, k >= int'(STOP_LVL[t])});
         end
         for (int k = 1; k <= int'(STOP_LVL[t]); k++)
         begin
            rw(1'b0, IDX_DATA, 8'h00);
            repeat (2) @(posedge clk_sys);
            chk(q, 8'h30 + 8'(k));
            chk({7'h0, rts_n_pin}, {7'h0, int'(STOP_LVL[t]) - k > int'(RES_LVL[t])});
         end
      end
      rw(1'b1, IDX_LCR, LCR_ENH_KEY);
      rw(1'b1, 3'h2, 8'hA0);
      rw(1'b1, IDX_LCR, 8'h03);
      rw(1'b1, IDX_IER, 8'h20);
      partner_u.send(8'h00);
      rw(1'b0, IDX_ISR, 8'h00);
      chk(q, ISR_XOFF | 8'hC0);
      partner_u.hold(1'b1);
      rw(1'b1, IDX_DATA, 8'h55);
      repeat (60) @(posedge clk_sys);
      chk(8'(partner_u.got.size()), 8'h01);
      partner_u.hold(1'b0);
      repeat (60) @(posedge clk_sys);
      chk(8'(partner_u.got.size()), 8'h02);
      tally_and_finish();
   end
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      tally_and_finish();
   end
endmodule : testbench
